// [rtl/cbp_pkg.sv]
`default_nettype none
package cbp_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_OP     = 8'h00;
  localparam logic [7:0] OFF_CORE   = 8'h04;
  localparam logic [7:0] OFF_ICTL   = 8'h08;
  localparam logic [7:0] OFF_STAT   = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_IST    = 8'h14;
  localparam logic [7:0] OFF_ICLR   = 8'h18;
  localparam logic [7:0] OFF_IEN    = 8'h1C;

  // op register fields
  localparam int OP_CODE_LSB = 0;
  localparam int OP_IMM_LSB  = 8;

  // core register fields
  localparam int CORE_ACC_LSB   = 0;
  localparam int CORE_X_LSB     = 4;
  localparam int CORE_Y_LSB     = 8;
  localparam int CORE_Z_LSB     = 12;
  localparam int CORE_CARRY_BIT = 16;
  localparam int CORE_LCH_BIT   = 17;
  localparam int CORE_B_LSB     = 20;
  localparam int CORE_MEM_LSB   = 24;

  // interrupt control register fields
  localparam int ICTL_V1_LSB = 0;
  localparam int ICTL_V2_LSB = 4;
  localparam int ICTL_I1_LSB = 8;
  localparam int EXT_IRQ_ENABLE_BIT  = 0;
  localparam int CONV_IRQ_ENABLE_BIT = 2;
  localparam int EXT_PIN_POLARITY_BIT = 2;

  // status register fields
  localparam int STAT_SKIP_BIT  = 8;
  localparam int STAT_BUSY_BIT  = 9;
  localparam int STAT_EXTF_BIT  = 10;
  localparam int STAT_CONVF_BIT = 11;
  localparam int STAT_PORTC_BIT = 12;
  localparam int STAT_PORTD_LSB = 16;
  localparam int STAT_PIN_BIT   = 24;
  localparam int STAT_CPIN_BIT  = 25;

  // interrupt events
  localparam int EV_SKIP   = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_BADY   = 2;
  localparam int EV_W      = 3;

  // port d has six bits, highest valid index
  localparam logic [3:0] PORTD_MAX_IDX = 4'h5;

  // reset value and response codes
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // operation codes
  typedef enum logic [4:0] {
    OP_NONE, OP_CARRY_CLEAR, OP_CARRY_SET, OP_PORTC_CLEAR, OP_PORTC_SET,
    OP_PORTC_SKIP_HIGH, OP_PORTD_BIT_CLEAR, OP_PORTD_BIT_SET, OP_RETURN_SUB,
    OP_RETURN_IRQ, OP_RETURN_SKIP, OP_SKIP_ACC_EQ_IMM, OP_SKIP_ACC_EQ_MEM,
    OP_SKIP_EXT_IRQ_FLAG, OP_SKIP_CONV_DONE_FLAG, OP_SKIP_EXT_PIN_LEVEL,
    OP_CALL, OP_IRQ_ENTRY
  } cbp_op_t;

endpackage
`default_nettype wire

// [rtl/cbp_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module cbp_sync import cbp_pkg::*; #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } cbp_sync_t;

  cbp_sync_t q_reg;
  cbp_sync_t q_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    q_next    = q_reg;
    q_next.s1 = pin_in;
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
    // only a level that held for two samples counts
    for (int i = 0; i < W; i++) begin
      if (q_reg.s2[i] == q_reg.s3[i]) begin
        q_next.lvl[i] = q_reg.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  assign level = q_reg.lvl;

endmodule // cbp_sync
`default_nettype wire

// [rtl/cbp_core.sv]
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cbp_core import cbp_pkg::*; #(
  parameter int DEPTH = 8,
  parameter int PCW   = 12
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  // axi4-lite write data
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  // pins from outside
  input  wire logic        ext_pin,
  input  wire logic        portc_pin,
  // flag set pulses, same clock
  input  wire logic        ext_irq_event,
  input  wire logic        conv_done_event,
  // outputs
  output var  logic        portc_out,
  output var  logic [5:0]  portd_out,
  output var  logic        irq
);

  localparam int SPW = $clog2(DEPTH);

  typedef struct packed {
    logic                      aw_full;
    logic [7:0]                aw_addr;
    logic                      w_full;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic [3:0]                acc;
    logic [3:0]                x;
    logic [3:0]                y;
    logic [1:0]                z;
    logic [3:0]                b;
    logic [3:0]                mem;
    logic                      carry;
    logic                      skip;
    logic                      lchain;
    logic                      portc;
    logic [5:0]                portd;
    logic [PCW-1:0]            pc;
    logic [SPW-1:0]            sp;
    logic [DEPTH-1:0][PCW-1:0] stack;
    logic [3:0]                v1;
    logic [3:0]                v2;
    logic [3:0]                i1;
    logic                      ext_flag;
    logic                      conv_flag;
    logic [3:0]                sx;
    logic [3:0]                sy;
    logic [1:0]                sz;
    logic [3:0]                sb;
    logic                      sc;
    logic                      ss;
    logic                      sl;
    logic                      busy;
    logic [EV_W-1:0]           ist;
    logic [EV_W-1:0]           ien;
    logic                      irq;
  } cbp_state_t;

  cbp_state_t q;
  cbp_state_t n;
  logic [1:0] pins;
  logic       pin_lvl;
  logic       cpin_lvl;
  logic       issue;
  cbp_op_t    op;
  logic [3:0] imm;

  ////////////////////////////////////////////////////////////////////////////
  // pin filters
  cbp_sync #(
    .W (2)
  ) i_cbp_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .pin_in  ({portc_pin, ext_pin}),
    .level   (pins)
  );
  assign pin_lvl  = pins[0];
  assign cpin_lvl = pins[1];

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_OP || a == OFF_CORE || a == OFF_ICTL || a == OFF_STAT ||
           a == OFF_PC || a == OFF_IST || a == OFF_ICLR || a == OFF_IEN;
  endfunction

  function automatic logic [31:0] core_word(input cbp_state_t s);
    logic [31:0] r;
    r = RST_WORD;
    r[CORE_ACC_LSB +: 4] = s.acc;
    r[CORE_X_LSB +: 4]   = s.x;
    r[CORE_Y_LSB +: 4]   = s.y;
    r[CORE_Z_LSB +: 2]   = s.z;
    r[CORE_CARRY_BIT]    = s.carry;
    r[CORE_LCH_BIT]      = s.lchain;
    r[CORE_B_LSB +: 4]   = s.b;
    r[CORE_MEM_LSB +: 4] = s.mem;
    return r;
  endfunction

  // an op write fires once address and data are both held, byte 0 is strobed and no op is busy
  assign issue = ce && q.aw_full && q.w_full && !q.bvalid && q.aw_addr == OFF_OP &&
                 !q.busy && q.w_strb[0];
  assign op    = cbp_op_t'(q.w_data[OP_CODE_LSB +: 5]);
  assign imm   = q.w_data[OP_IMM_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0]     wv;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic            ext_clr;
    logic            conv_clr;
    wv       = RST_WORD;
    ev       = '0;
    clr      = '0;
    ext_clr  = 1'b0;
    conv_clr = 1'b0;
    n        = q;
    n.busy   = 1'b0;

    // read channel
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        OFF_CORE: n.rdata = core_word(q);
        OFF_ICTL: n.rdata = {20'h0_0000, q.i1, q.v2, q.v1};
        OFF_STAT: begin
          n.rdata = RST_WORD;
          n.rdata[SPW-1:0]                = q.sp;
          n.rdata[STAT_SKIP_BIT]          = q.skip;
          n.rdata[STAT_BUSY_BIT]          = q.busy;
          n.rdata[STAT_EXTF_BIT]          = q.ext_flag;
          n.rdata[STAT_CONVF_BIT]         = q.conv_flag;
          n.rdata[STAT_PORTC_BIT]         = q.portc;
          n.rdata[STAT_PORTD_LSB +: 6]    = q.portd;
          n.rdata[STAT_PIN_BIT]           = pin_lvl;
          n.rdata[STAT_CPIN_BIT]          = cpin_lvl;
        end
        OFF_PC:  n.rdata = {{(32-PCW){1'b0}}, q.pc};
        OFF_IST: n.rdata = {{(32-EV_W){1'b0}}, q.ist};
        OFF_IEN: n.rdata = {{(32-EV_W){1'b0}}, q.ien};
        default: n.rdata = RST_WORD;
      endcase
    end else if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end

    // write channels, taken in either order
    if (awvalid && q.awready) begin
      n.aw_full = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_full = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (q.aw_addr)
        OFF_OP: begin
          // a second op while one is still running is dropped
          if (q.busy) begin
            ev[EV_REFUSE] = 1'b1;
          end
        end
        OFF_CORE: begin
          wv       = merge(core_word(q), q.w_data, q.w_strb);
          n.acc    = wv[CORE_ACC_LSB +: 4];
          n.x      = wv[CORE_X_LSB +: 4];
          n.y      = wv[CORE_Y_LSB +: 4];
          n.z      = wv[CORE_Z_LSB +: 2];
          n.carry  = wv[CORE_CARRY_BIT];
          n.lchain = wv[CORE_LCH_BIT];
          n.b      = wv[CORE_B_LSB +: 4];
          n.mem    = wv[CORE_MEM_LSB +: 4];
        end
        OFF_ICTL: begin
          wv   = merge({20'h0_0000, q.i1, q.v2, q.v1}, q.w_data, q.w_strb);
          n.v1 = wv[ICTL_V1_LSB +: 4];
          n.v2 = wv[ICTL_V2_LSB +: 4];
          n.i1 = wv[ICTL_I1_LSB +: 4];
        end
        OFF_PC: begin
          wv   = merge({{(32-PCW){1'b0}}, q.pc}, q.w_data, q.w_strb);
          n.pc = wv[PCW-1:0];
        end
        OFF_ICLR: clr = q.w_strb[0] ? q.w_data[EV_W-1:0] : '0;
        OFF_IEN: begin
          if (q.w_strb[0]) begin
            n.ien = q.w_data[EV_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // execution
    if (issue && q.skip) begin
      // the op under a pending skip is passed over whole
      n.skip = 1'b0;
      n.pc   = q.pc + ((op == OP_SKIP_ACC_EQ_IMM) ? PCW'(2) : PCW'(1));
    end else if (issue) begin
      n.pc   = q.pc + PCW'(1);
      n.skip = 1'b0;
      case (op)
        OP_CARRY_CLEAR: n.carry = 1'b0;
        OP_CARRY_SET:   n.carry = 1'b1;
        OP_PORTC_CLEAR:     n.portc = 1'b0;
        OP_PORTC_SET:       n.portc = 1'b1;
        OP_PORTC_SKIP_HIGH: n.skip  = cpin_lvl;
        OP_PORTD_BIT_CLEAR, OP_PORTD_BIT_SET: begin
          if (q.y <= PORTD_MAX_IDX) begin
            n.portd[q.y[2:0]] = (op == OP_PORTD_BIT_SET);
          end else begin
            ev[EV_BADY] = 1'b1;
          end
        end
        OP_RETURN_SUB: begin
          n.pc   = q.stack[q.sp];
          n.sp   = q.sp - SPW'(1);
          n.busy = 1'b1;
        end
        OP_RETURN_IRQ: begin
          n.pc     = q.stack[q.sp];
          n.sp     = q.sp - SPW'(1);
          n.x      = q.sx;
          n.y      = q.sy;
          n.z      = q.sz;
          n.b      = q.sb;
          n.carry  = q.sc;
          n.skip   = q.ss;
          n.lchain = q.sl;
          n.busy   = 1'b1;
        end
        OP_RETURN_SKIP: begin
          n.pc   = q.stack[q.sp];
          n.sp   = q.sp - SPW'(1);
          n.skip = 1'b1;
          n.busy = 1'b1;
        end
        OP_SKIP_ACC_EQ_IMM: begin
          n.pc   = q.pc + PCW'(2);
          n.skip = (q.acc == imm);
          n.busy = 1'b1;
        end
        OP_SKIP_ACC_EQ_MEM: n.skip = (q.acc == q.mem);
        OP_SKIP_EXT_IRQ_FLAG: begin
          if (!q.v1[EXT_IRQ_ENABLE_BIT]) begin
            n.skip  = q.ext_flag;
            ext_clr = q.ext_flag;
          end
        end
        OP_SKIP_CONV_DONE_FLAG: begin
          if (!q.v2[CONV_IRQ_ENABLE_BIT]) begin
            n.skip   = q.conv_flag;
            conv_clr = q.conv_flag;
          end
        end
        OP_SKIP_EXT_PIN_LEVEL: n.skip = (pin_lvl == q.i1[EXT_PIN_POLARITY_BIT]);
        OP_CALL: begin
          n.sp           = q.sp + SPW'(1);
          n.stack[n.sp]  = q.pc + PCW'(1);
        end
        OP_IRQ_ENTRY: begin
          // pc is not advanced: the interrupted op resumes on return
          n.sp          = q.sp + SPW'(1);
          n.stack[n.sp] = q.pc;
          n.pc          = q.pc;
          n.sx          = q.x;
          n.sy          = q.y;
          n.sz          = q.z;
          n.sb          = q.b;
          n.sc          = q.carry;
          n.ss          = q.skip;
          n.sl          = q.lchain;
        end
        default: ;
      endcase
      ev[EV_SKIP] = n.skip;
    end

    // a set arriving with its clear wins
    n.ext_flag  = (q.ext_flag & ~ext_clr) | ext_irq_event;
    n.conv_flag = (q.conv_flag & ~conv_clr) | conv_done_event;
    n.ist       = (q.ist & ~clr) | ev;
    n.irq       = |(n.ist & n.ien);

    n.awready = !n.aw_full && !n.bvalid;
    n.wready  = !n.w_full && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q    <= '0;
      q.sp <= '1;
    end else if (ce) begin
      q <= n;
    end
  end

  assign awready   = q.awready;
  assign wready    = q.wready;
  assign bvalid    = q.bvalid;
  assign bresp     = q.bresp;
  assign arready   = q.arready;
  assign rvalid    = q.rvalid;
  assign rdata     = q.rdata;
  assign rresp     = q.rresp;
  assign portc_out = q.portc;
  assign portd_out = q.portd;
  assign irq       = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // carry clear check
  AST_CARRY_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_CARRY_CLEAR |=> !q.carry && $stable(q.acc) && $stable(q.b))
    else $error("carry not cleared");

  AST_CARRY_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_CARRY_SET |=> q.carry && !q.skip)
    else $error("carry not set");

  AST_PORTD_BIT: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && (op == OP_PORTD_BIT_SET || op == OP_PORTD_BIT_CLEAR) &&
    q.y <= PORTD_MAX_IDX |=> portd_out[$past(q.y[2:0])] == ($past(op) == OP_PORTD_BIT_SET))
    else $error("port d bit wrong");

  AST_PORTD_NOP: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && (op == OP_PORTD_BIT_SET || op == OP_PORTD_BIT_CLEAR) &&
    q.y > PORTD_MAX_IDX |=> $stable(portd_out) ##1 q.ist[EV_BADY])
    else $error("port d changed for bad index");

  AST_RET_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_RETURN_IRQ |=> q.x == $past(q.sx) && q.y == $past(q.sy) &&
    q.carry == $past(q.sc) && q.b == $past(q.sb) && q.skip == $past(q.ss) && q.busy)
    else $error("context not restored");

  AST_RET_SKIP: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_RETURN_SKIP |=> q.skip && q.sp == $past(q.sp) - SPW'(1) &&
    q.pc == $past(q.stack[q.sp]))
    else $error("return and skip wrong");

  AST_SKIP_IMM: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_SKIP_ACC_EQ_IMM |=> q.busy &&
    q.skip == ($past(q.acc) == $past(imm)) && q.pc == $past(q.pc) + PCW'(2))
    else $error("immediate compare wrong");

  AST_EXT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_SKIP_EXT_IRQ_FLAG && !q.v1[EXT_IRQ_ENABLE_BIT] &&
    q.ext_flag && !ext_irq_event |=> q.skip && !q.ext_flag)
    else $error("ext flag test wrong");

  AST_CONV_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_SKIP_CONV_DONE_FLAG &&
    q.v2[CONV_IRQ_ENABLE_BIT] |=> !q.skip && q.conv_flag == $past(q.conv_flag | conv_done_event))
    else $error("conversion test not a no-op");

  AST_PIN_LVL: assert property (@(posedge aclk) disable iff (!aresetn)
    issue && !q.skip && op == OP_SKIP_EXT_PIN_LEVEL |=>
    q.skip == ($past(pin_lvl) == $past(q.i1[EXT_PIN_POLARITY_BIT])))
    else $error("pin level test wrong");

endmodule // cbp_core
`default_nettype wire

// [testbench/cpu_bit_port_skip_return_ops_test.sv]
`timescale 1ns/1ns
`default_nettype none
module cpu_bit_port_skip_return_ops_test import cbp_pkg::*; ;
  // bus and pins
  logic        aclk, aresetn, ce;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        ext_pin, portc_pin, ext_irq_event, conv_done_event;
  logic        portc_out, irq;
  logic [5:0]  portd_out;
  int          failures, compares;

  cbp_core i_cbp_core (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ext_pin(ext_pin), .portc_pin(portc_pin), .ext_irq_event(ext_irq_event),
    .conv_done_event(conv_done_event), .portc_out(portc_out),
    .portd_out(portd_out), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ready values read at the edge are the pre-edge ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    bit done;
    done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        chk({30'h0, bresp}, {30'h0, er});
      end
    end
    bready <= 1'b0;
    @(posedge aclk);
    if (!done) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    bit done;
    done = 0;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    rready <= 1'b0;
    @(posedge aclk);
    if (!done) begin
      failures++;
      complete_run();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask

  // two idle edges cover the busy slot of return and immediate compare ops
  task automatic op(input cbp_op_t c, input logic [3:0] n = 4'h0);
    wr(OFF_OP, {20'h0_0000, n, 3'h0, c});
    repeat (2) @(posedge aclk);
  endtask

  // a pending skip is consumed by a discarded no-op
  task automatic sk(input cbp_op_t c, input logic [3:0] n, input logic e);
    op(c, n);
    rc(OFF_STAT, 32'h100, {23'h0, e, 8'h00});
    if (e) op(OP_NONE);
  endtask

  task automatic pulse(input bit conv);
    if (conv) conv_done_event <= 1'b1;
    else ext_irq_event <= 1'b1;
    @(posedge aclk);
    conv_done_event <= 1'b0;
    ext_irq_event <= 1'b0;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////
  task automatic t_carry();
    wr(OFF_CORE, 32'h0A92_1A7C);
    op(OP_CARRY_SET);
    rc(OFF_CORE, 32'h0FF3_3FFF, 32'h0A93_1A7C);
    op(OP_CARRY_CLEAR);
    rc(OFF_CORE, 32'h0FF3_3FFF, 32'h0A92_1A7C);
  endtask

  task automatic t_portd();
    logic [5:0] e;
    e = 6'h00;
    wr(OFF_IEN, 32'h4);
    for (int s = 0; s < 2; s++) begin
      for (int y = 0; y < 8; y++) begin
        wr(OFF_CORE, {20'h0_0000, y[3:0], 8'h00});
        op(s ? OP_PORTD_BIT_CLEAR : OP_PORTD_BIT_SET);
        if (y <= 5) e[y] = ~s[0];
        chk({26'h0, portd_out}, {26'h0, e});
      end
    end
    rc(OFF_IST, 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IEN, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_ICLR, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IEN, 32'h0);
  endtask

  task automatic t_portc();
    op(OP_PORTC_SET);
    chk({31'h0, portc_out}, 32'h1);
    op(OP_PORTC_CLEAR);
    chk({31'h0, portc_out}, 32'h0);
    for (int l = 1; l >= 0; l--) begin
      portc_pin <= l[0];
      // filter needs 3-4 cycles, 8 leaves margin
      repeat (8) @(posedge aclk);
      sk(OP_PORTC_SKIP_HIGH, 4'h0, l[0]);
    end
  endtask

  task automatic t_cmp();
    wr(OFF_CORE, 32'h0700_000F);
    sk(OP_SKIP_ACC_EQ_IMM, 4'hF, 1'b1);
    sk(OP_SKIP_ACC_EQ_IMM, 4'h0, 1'b0);
    sk(OP_SKIP_ACC_EQ_MEM, 4'h0, 1'b0);
    wr(OFF_CORE, 32'h0700_0007);
    sk(OP_SKIP_ACC_EQ_IMM, 4'h7, 1'b1);
    sk(OP_SKIP_ACC_EQ_IMM, 4'h6, 1'b0);
    sk(OP_SKIP_ACC_EQ_MEM, 4'h0, 1'b1);
  endtask

  task automatic t_flag();
    cbp_op_t c;
    for (int f = 0; f < 2; f++) begin
      c = f ? OP_SKIP_CONV_DONE_FLAG : OP_SKIP_EXT_IRQ_FLAG;
      for (int en = 0; en < 2; en++) begin
        wr(OFF_ICTL, en ? (f ? 32'h40 : 32'h1) : 32'h0);
        pulse(f[0]);
        sk(c, 4'h0, ~en[0]);
        rc(OFF_STAT, 32'h400 << f, en ? 32'h400 << f : 32'h0);
      end
      wr(OFF_ICTL, 32'h0);
      sk(c, 4'h0, 1'b1);
      sk(c, 4'h0, 1'b0);
    end
  endtask

  task automatic t_pin();
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < 2; l++) begin
        wr(OFF_ICTL, {21'h0, p[0], 10'h000});
        ext_pin <= l[0];
        repeat (8) @(posedge aclk);
        sk(OP_SKIP_EXT_PIN_LEVEL, 4'h0, p == l);
      end
    end
    wr(OFF_ICTL, 32'h0);
  endtask

  task automatic t_ret();
    wr(OFF_PC, 32'h123);
    wr(OFF_CORE, 32'h0A93_1A7C);
    op(OP_IRQ_ENTRY);
    wr(OFF_CORE, 32'h0560_2585);
    op(OP_RETURN_IRQ);
    rc(OFF_CORE, 32'h00F3_3FF0, 32'h0093_1A70);
    rc(OFF_PC, 32'hFFF, 32'h123);
    rc(OFF_STAT, 32'h107, 32'h7);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_PC, 32'h200);
      op(OP_CALL);
      rc(OFF_STAT, 32'h7, 32'h0);
      op(k ? OP_RETURN_SKIP : OP_RETURN_SUB);
      rc(OFF_STAT, 32'h107, k ? 32'h107 : 32'h7);
      rc(OFF_PC, 32'hFFF, 32'h201);
    end
    op(OP_NONE);
    rc(OFF_PC, 32'hFFF, 32'h202);
  endtask

  task automatic t_reset();
    rc(OFF_STAT, 32'h003F_1F07, 32'h7);
    chk({25'h0, irq, portd_out}, 32'h0);
  endtask

  // ce low and an op word without byte 0 must both leave state alone
  task automatic t_hold();
    ce <= 1'b0;
    pulse(1'b1);
    ce <= 1'b1;
    rc(OFF_STAT, 32'h800, 32'h0);
    wstrb <= 4'hE;
    op(OP_PORTC_SET);
    wstrb <= 4'hF;
    chk({31'h0, portc_out}, 32'h0);
  endtask

  task automatic t_map();
    rd(8'h20, v, RESP_SLVERR);
    chk(v, 32'h0);
    wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  ////////////////////////////////////////////////
  initial begin
    failures = 0;
    compares = 0;
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
    {ext_pin, portc_pin, ext_irq_event, conv_done_event} = 4'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hF;
    ce = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_carry();
    t_portd();
    t_portc();
    t_hold();
    t_cmp();
    t_flag();
    t_pin();
    t_ret();
    t_map();
    complete_run();
  end
endmodule // cpu_bit_port_skip_return_ops_test
`default_nettype wire
